/* e1tii_pkg.sv */
// constants shared by the e1 transmit input device end and terminal end
//
// Functional notes
// RULE1 - clock activity selects clocked mode automatically
// RULE2 - terminal drives 2.048 MHz bit clock; the terminal uses a 48-cycle, 480 ns period, about 2.083 MHz
// RULE3 - clocked mode: full-period NRZ mark levels
// RULE4 - device samples marks on clock falling edge
// RULE5 - positive mark gives positive line symbol
// RULE6 - negative mark gives negative line symbol
// RULE7 - clockless: bit clock held high, no toggling
// RULE8 - clockless: half-bit RZ mark on matching input
// RULE9 - clockless: RZ mark in first half
// RULE10 - clockless: both marks low second half
// RULE11 - exactly one line symbol per mark
// RULE12 - no mark means zero-level space
// RULE13 - idle clock falls back to clockless mode
package e1tii_pkg;
    // time base
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int BIT_PERIOD_NS = 488;
    localparam int SYMBOL_WIDTH_NS = 244;
    // bit period on the 100 MHz clock, rounded down (shorter time)
    localparam int BIT_CYCLES = BIT_PERIOD_NS / CLOCK_PERIOD_NS;
    // line symbol width rounded up to whole cycles
    localparam int SYMBOL_CYCLES = (SYMBOL_WIDTH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // bit periods without an edge before the clock counts as gone
    localparam int IDLE_BITS = 4;
    localparam int IDLE_CYCLES = IDLE_BITS * BIT_CYCLES;
    // counter width used by both ends
    localparam int CNT_W = 8;
    // line symbol {tip, ring}
    localparam logic [1:0] LINE_SPACE = 2'h0;
    localparam logic [1:0] LINE_POS = 2'h2;
    localparam logic [1:0] LINE_NEG = 2'h1;
    // mark word layout {positive, negative}
    localparam int MARK_W = 2;
    localparam int MARK_POS_BIT = 1;
    localparam int MARK_NEG_BIT = 0;
    // link pins at rest {clock, positive, negative}: clock high, marks low
    localparam logic [2:0] PIN_IDLE = 3'h4;
    // terminal buffer depth
    localparam int BUF_DEPTH = 2;
endpackage : e1tii_pkg

/* e1tii_link_if.sv */
// link between terminal equipment and the e1 transmit input device
`timescale 1ns/1ps
interface e1tii_link_if;
    logic tx_bit_clock_in;
    logic tx_positive_mark_in;
    logic tx_negative_mark_in;

    modport device (
        input tx_bit_clock_in,
        input tx_positive_mark_in,
        input tx_negative_mark_in
    );

    modport terminal (
        output tx_bit_clock_in,
        output tx_positive_mark_in,
        output tx_negative_mark_in
    );
endinterface : e1tii_link_if

/* e1tii_device.sv */
// device end: mode detect, mark capture and bipolar line symbol generation
`timescale 1ns/1ps
module e1tii_device #(
    parameter int SYMBOL_CYCLES = e1tii_pkg::SYMBOL_CYCLES,
    parameter int IDLE_CYCLES = e1tii_pkg::IDLE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst,
    e1tii_link_if.device link,
    output logic o_line_out_tip,
    output logic o_line_out_ring,
    output logic o_clocked_mode,
    output logic o_double_mark,
    output logic o_polarity_repeat
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // counters are CNT_W bits wide
    if (SYMBOL_CYCLES < 1 || SYMBOL_CYCLES > 255) begin : g_bad_symbol
        $error("e1tii_device: SYMBOL_CYCLES out of range");
    end
    if (IDLE_CYCLES < 2 || IDLE_CYCLES > 255) begin : g_bad_idle
        $error("e1tii_device: IDLE_CYCLES out of range");
    end

    localparam logic [e1tii_pkg::CNT_W-1:0] SYMBOL_LOAD = e1tii_pkg::CNT_W'(SYMBOL_CYCLES);
    localparam logic [e1tii_pkg::CNT_W-1:0] IDLE_LIMIT = e1tii_pkg::CNT_W'(IDLE_CYCLES);
    localparam logic [e1tii_pkg::CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [e1tii_pkg::CNT_W-1:0] CNT_ONE = e1tii_pkg::CNT_W'(1);

    ////////////////////////////////////////////////////////////////////////////
    // edge helpers

    // an edge is a difference between the second stage and its delayed copy
    function automatic logic rise_seen(input logic now_v, input logic prev_v);
        rise_seen = now_v && !prev_v;
    endfunction : rise_seen

    function automatic logic fall_seen(input logic now_v, input logic prev_v);
        fall_seen = prev_v && !now_v;
    endfunction : fall_seen

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // all three link pins come from another clock, so each passes two flops;
    // clock and data see the same delay, so capture timing is kept;
    // the third stage is only a delayed copy for edge detection
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_d;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            // rest levels, so no false mark edge follows reset
            sync_a <= e1tii_pkg::PIN_IDLE;
            sync_b <= e1tii_pkg::PIN_IDLE;
            sync_d <= e1tii_pkg::PIN_IDLE;
        end else begin
            sync_a <= {link.tx_bit_clock_in, link.tx_positive_mark_in,
                       link.tx_negative_mark_in};
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    logic clk_now;
    logic clk_prev;
    logic pos_now;
    logic pos_prev;
    logic neg_now;
    logic neg_prev;

    // only the second stage and its delayed copy are looked at
    assign clk_now = sync_b[2];
    assign clk_prev = sync_d[2];
    assign pos_now = sync_b[1];
    assign pos_prev = sync_d[1];
    assign neg_now = sync_b[0];
    assign neg_prev = sync_d[0];

    ////////////////////////////////////////////////////////////////////////////
    // clock activity detector

    logic clocked;
    logic next_clocked;
    logic [e1tii_pkg::CNT_W-1:0] idle_cnt;
    logic [e1tii_pkg::CNT_W-1:0] next_idle_cnt;

    // any edge means clocked; a quiet stretch means clockless again.
    // a single glitch on a floating pin can flip the mode for a while.
    // the idle limit must exceed half a bit, or a live clock would look idle
    always_comb begin
        next_clocked = clocked;
        next_idle_cnt = idle_cnt;
        if (clk_now != clk_prev) begin
            next_clocked = 1'b1; // RULE1
            next_idle_cnt = CNT_ZERO;
        end else if (idle_cnt >= IDLE_LIMIT - CNT_ONE) begin
            next_clocked = 1'b0; // RULE13
        end else begin
            next_idle_cnt = idle_cnt + CNT_ONE;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            clocked <= 1'b0;
            idle_cnt <= CNT_ZERO;
        end else begin
            clocked <= next_clocked;
            idle_cnt <= next_idle_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mark capture

    logic mark_pos;
    logic mark_neg;

    // clocked: sample both levels on the falling clock edge.
    // clockless: each rising edge of an RZ input is one mark
    always_comb begin
        mark_pos = 1'b0;
        mark_neg = 1'b0;
        if (clocked) begin
            if (fall_seen(clk_now, clk_prev)) begin
                mark_pos = pos_now; // RULE4
                mark_neg = neg_now; // RULE4
            end
        end else begin
            // relies on the input going low in the second half of each bit
            mark_pos = rise_seen(pos_now, pos_prev); // RULE8 RULE10
            mark_neg = rise_seen(neg_now, neg_prev); // RULE8 RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // line symbol generator

    logic [1:0] line;
    logic [1:0] next_line;
    logic [e1tii_pkg::CNT_W-1:0] width_cnt;
    logic [e1tii_pkg::CNT_W-1:0] next_width_cnt;
    logic last_pol_pos;
    logic next_last_pol_pos;
    logic have_last;
    logic next_have_last;
    logic double_mark;
    logic next_double_mark;
    logic pol_repeat;
    logic next_pol_repeat;

    // one symbol per mark; a new mark restarts the width so none is merged.
    // both marks at once is not a valid symbol; it is flagged and starts no symbol
    always_comb begin
        next_line = line;
        next_width_cnt = width_cnt;
        next_last_pol_pos = last_pol_pos;
        next_have_last = have_last;
        next_double_mark = 1'b0;
        next_pol_repeat = 1'b0;
        if (width_cnt != CNT_ZERO) begin
            next_width_cnt = width_cnt - CNT_ONE;
        end
        if (width_cnt == CNT_ONE) begin
            next_line = e1tii_pkg::LINE_SPACE; // RULE12
        end
        // a word of both marks is only flagged; the line keeps its symbol
        if (mark_pos && mark_neg) begin
            next_double_mark = 1'b1;
        end else if (mark_pos || mark_neg) begin
            next_width_cnt = SYMBOL_LOAD; // RULE11
            next_line = mark_pos ? e1tii_pkg::LINE_POS : e1tii_pkg::LINE_NEG; // RULE5 RULE6
            next_pol_repeat = have_last && (last_pol_pos == mark_pos);
            next_last_pol_pos = mark_pos;
            next_have_last = 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            line <= e1tii_pkg::LINE_SPACE;
            width_cnt <= CNT_ZERO;
            last_pol_pos <= 1'b0;
            have_last <= 1'b0;
            double_mark <= 1'b0;
            pol_repeat <= 1'b0;
        end else begin
            line <= next_line;
            width_cnt <= next_width_cnt;
            last_pol_pos <= next_last_pol_pos;
            have_last <= next_have_last;
            double_mark <= next_double_mark;
            pol_repeat <= next_pol_repeat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flop
    // tip and ring cannot be high together: line holds one symbol code

    assign o_line_out_tip = line[1];
    assign o_line_out_ring = line[0];
    assign o_clocked_mode = clocked;
    assign o_double_mark = double_mark;
    assign o_polarity_repeat = pol_repeat;

endmodule : e1tii_device

/* e1tii_terminal.sv */
// terminal end: buffers mark words and drives them in clocked or clockless form
`timescale 1ns/1ps
module e1tii_terminal #(
    parameter int BIT_CYCLES = e1tii_pkg::BIT_CYCLES,
    parameter int DEPTH = e1tii_pkg::BUF_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clocked_mode,
    input wire logic i_data_valid,
    input wire logic [e1tii_pkg::MARK_W-1:0] i_data_mark,
    output logic o_data_ready,
    e1tii_link_if.terminal link
);

    if (BIT_CYCLES < 4 || BIT_CYCLES > 255 || DEPTH < 2 || DEPTH > 16) begin : g_bad
        $error("e1tii_terminal: BIT_CYCLES or DEPTH out of range");
    end

    localparam int PW = e1tii_pkg::CNT_W;
    localparam logic [PW-1:0] LAST = PW'(BIT_CYCLES - 1);
    localparam logic [PW-1:0] HALF = PW'(BIT_CYCLES / 2);
    localparam logic [4:0] FULL = 5'(DEPTH);

    function automatic logic [3:0] wrap_inc(input logic [3:0] p);
        wrap_inc = (p == 4'(DEPTH - 1)) ? 4'h0 : p + 4'h1;
    endfunction : wrap_inc

    ////////////////////////////////////////////////////////////////////////////
    // word buffer; drained once per bit, so a slow bit rate fills it

    logic [e1tii_pkg::MARK_W-1:0] mem [DEPTH];
    logic [3:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [4:0] count, next_count;
    logic ready, next_ready;
    logic [PW-1:0] phase, next_phase;
    logic [e1tii_pkg::MARK_W-1:0] sym, next_sym;
    logic mode, next_mode;
    logic push, pop;

    assign push = i_data_valid && ready;
    assign pop = (phase == LAST) && (count != 5'h00);

    // a word is taken at the bit boundary; an empty buffer sends a space
    always_comb begin
        next_wr_ptr = push ? wrap_inc(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? wrap_inc(rd_ptr) : rd_ptr;
        next_count = count + {4'h0, push} - {4'h0, pop};
        next_ready = next_count < FULL;
        next_phase = (phase == LAST) ? '0 : phase + PW'(1);
        next_sym = sym;
        next_mode = mode;
        if (phase == LAST) begin
            next_sym = pop ? mem[rd_ptr[$clog2(DEPTH)-1:0]] : '0;
            next_mode = i_clocked_mode;
        end
    end

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr[$clog2(DEPTH)-1:0]] <= i_data_mark;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link drive from the next state, so pins come from flops

    logic clk_o, pos_o, neg_o;
    logic next_clk_o, next_pos_o, next_neg_o;
    logic first_half;

    assign first_half = next_phase < HALF;

    always_comb begin
        if (next_mode) begin
            next_clk_o = first_half; // RULE2
            next_pos_o = next_sym[e1tii_pkg::MARK_POS_BIT]; // RULE3
            next_neg_o = next_sym[e1tii_pkg::MARK_NEG_BIT]; // RULE3
        end else begin
            next_clk_o = 1'b1; // RULE7
            next_pos_o = next_sym[e1tii_pkg::MARK_POS_BIT] && first_half; // RULE8 RULE9 RULE10
            next_neg_o = next_sym[e1tii_pkg::MARK_NEG_BIT] && first_half; // RULE8 RULE9 RULE10
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count <= 5'h00;
            ready <= 1'b0;
            phase <= '0;
            sym <= '0;
            mode <= 1'b0;
            clk_o <= 1'b1;
            pos_o <= 1'b0;
            neg_o <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            ready <= next_ready;
            phase <= next_phase;
            sym <= next_sym;
            mode <= next_mode;
            clk_o <= next_clk_o;
            pos_o <= next_pos_o;
            neg_o <= next_neg_o;
        end
    end

    assign o_data_ready = ready;
    assign link.tx_bit_clock_in = clk_o;
    assign link.tx_positive_mark_in = pos_o;
    assign link.tx_negative_mark_in = neg_o;

endmodule : e1tii_terminal

/* e1tii_monitor.sv */
// concurrent checks on the e1 transmit link and the device line outputs
`timescale 1ns/1ps
module e1tii_monitor #(
    parameter int SYMBOL_CYCLES = 25,
    parameter int IDLE_CYCLES = 192
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_tx_bit_clock_in,
    input wire logic i_tx_positive_mark_in,
    input wire logic i_tx_negative_mark_in,
    input wire logic i_line_out_tip,
    input wire logic i_line_out_ring,
    input wire logic i_clocked_mode,
    input wire logic i_double_mark
);
    logic clk_q;
    logic [8:0] run;
    logic [8:0] quiet;
    logic [8:0] clk_idle;
    logic [8:0] next_run;
    logic [8:0] next_quiet;
    logic [8:0] next_clk_idle;
    ////////////////////////////////////////////////////////////////////////////////
    // line activity length, mark-free time, time since the last clock pin edge
    always_comb begin
        next_run = (i_line_out_tip | i_line_out_ring) ? run + 9'h001 : 9'h000;
        next_quiet = (i_tx_positive_mark_in | i_tx_negative_mark_in) ? 9'h000
            : quiet + {8'h00, ~&quiet};
        next_clk_idle = (i_tx_bit_clock_in != clk_q) ? 9'h000
            : clk_idle + {8'h00, ~&clk_idle};
    end
    // quiet and clk_idle saturate so a long idle spell never wraps back into range; run does not
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            clk_q <= 1'b1;
            run <= 9'h000;
            quiet <= 9'h000;
            clk_idle <= 9'h000;
        end else begin
            clk_q <= i_tx_bit_clock_in;
            run <= next_run;
            quiet <= next_quiet;
            clk_idle <= next_clk_idle;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    a_rz_pos_tip: assert property (
        !i_clocked_mode && $rose(i_tx_positive_mark_in) && !i_tx_negative_mark_in
        |-> ##[3:4] (i_line_out_tip && !i_line_out_ring))
        else $error("rz positive mark lost");
    a_rz_neg_ring: assert property (
        !i_clocked_mode && $rose(i_tx_negative_mark_in) && !i_tx_positive_mark_in
        |-> ##[3:4] (i_line_out_ring && !i_line_out_tip))
        else $error("rz negative mark lost");
    a_nrz_fall_capture: assert property (
        i_clocked_mode && $fell(i_tx_bit_clock_in) && i_tx_positive_mark_in
        && !i_tx_negative_mark_in |-> ##[2:6] i_line_out_tip)
        else $error("nrz mark not captured");
    a_line_never_both: assert property (
        !(i_line_out_tip && i_line_out_ring))
        else $error("tip and ring high together");
    a_symbol_width: assert property (
        $fell(i_line_out_tip | i_line_out_ring) |-> run == SYMBOL_CYCLES)
        else $error("line symbol width wrong");
    a_no_mark_space: assert property (
        quiet > SYMBOL_CYCLES + 6 |-> !i_line_out_tip && !i_line_out_ring)
        else $error("line active without a mark");
    a_clock_enters_mode: assert property (
        !i_clocked_mode && $fell(i_tx_bit_clock_in) |-> ##[2:6] i_clocked_mode)
        else $error("clocked mode not entered");
    a_idle_falls_back: assert property (
        clk_idle > IDLE_CYCLES + 8 |-> !i_clocked_mode)
        else $error("clocked mode kept without clock");
    a_double_flagged: assert property (
        i_clocked_mode && $fell(i_tx_bit_clock_in) && i_tx_positive_mark_in
        && i_tx_negative_mark_in |-> ##[2:6] i_double_mark)
        else $error("double mark not flagged");
    c_tip_seen: cover property ($rose(i_line_out_tip));
    c_ring_seen: cover property ($rose(i_line_out_ring));
    c_double_seen: cover property (i_double_mark);
    c_fallback_seen: cover property ($fell(i_clocked_mode));
endmodule : e1tii_monitor

/* testbench.sv */
// self-checking bench joining the terminal end to the device end
`timescale 1ns/1ps
module testbench;
    logic i_clock;
    logic i_rst;
    logic i_clocked_mode;
    logic i_data_valid;
    logic [e1tii_pkg::MARK_W-1:0] i_data_mark;
    logic o_data_ready;
    logic o_line_out_tip;
    logic o_line_out_ring;
    logic o_clocked_mode;
    logic o_double_mark;
    logic o_polarity_repeat;
    logic clk_q, tip_q, ring_q;
    logic [15:0] n_tip, n_ring, n_dbl, n_pos_hi, n_clk_edge, n_take, n_rep;
    int mismatches;
    int samples_checked;
    e1tii_link_if link ();
    e1tii_terminal e1tii_terminal_i (.i_clock(i_clock), .i_rst(i_rst),
        .i_clocked_mode(i_clocked_mode), .i_data_valid(i_data_valid),
        .i_data_mark(i_data_mark), .o_data_ready(o_data_ready), .link(link));
    e1tii_device #(.SYMBOL_CYCLES(e1tii_pkg::SYMBOL_CYCLES),
        .IDLE_CYCLES(e1tii_pkg::IDLE_CYCLES)) e1tii_device_i (.i_clock(i_clock), .i_rst(i_rst),
        .link(link), .o_line_out_tip(o_line_out_tip), .o_line_out_ring(o_line_out_ring),
        .o_clocked_mode(o_clocked_mode), .o_double_mark(o_double_mark),
        .o_polarity_repeat(o_polarity_repeat));
    e1tii_monitor #(.SYMBOL_CYCLES(e1tii_pkg::SYMBOL_CYCLES),
        .IDLE_CYCLES(e1tii_pkg::IDLE_CYCLES)) e1tii_monitor_i (.i_clock(i_clock), .i_rst(i_rst),
        .i_tx_bit_clock_in(link.tx_bit_clock_in),
        .i_tx_positive_mark_in(link.tx_positive_mark_in),
        .i_tx_negative_mark_in(link.tx_negative_mark_in), .i_line_out_tip(o_line_out_tip),
        .i_line_out_ring(o_line_out_ring), .i_clocked_mode(o_clocked_mode),
        .i_double_mark(o_double_mark));
    ////////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial i_clock = 1'b0;
    always #5 i_clock = ~i_clock;
    // event counts read at the edge, before any flop of the design moves
    always @(posedge i_clock) begin
        if (o_line_out_tip && !tip_q) n_tip++;
        if (o_line_out_ring && !ring_q) n_ring++;
        if (o_double_mark) n_dbl++;
        if (o_polarity_repeat) n_rep++;
        if (link.tx_positive_mark_in) n_pos_hi++;
        if (link.tx_bit_clock_in !== clk_q) n_clk_edge++;
        if (i_data_valid && o_data_ready) n_take++;
        clk_q = link.tx_bit_clock_in;
        tip_q = o_line_out_tip;
        ring_q = o_line_out_ring;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check
    task automatic clear;
        {n_tip, n_ring, n_dbl, n_pos_hi, n_clk_edge, n_take, n_rep} = '0;
    endtask : clear
    // offer one word once ready is seen; ready only moves on the rising edge
    task automatic put(input logic [1:0] m);
        int k;
        k = 0;
        @(negedge i_clock);
        while (o_data_ready !== 1'b1 && k < 200) begin
            @(negedge i_clock);
            k++;
        end
        check("ready wait", 16'h0001, {15'h0000, o_data_ready});
        i_data_valid = 1'b1;
        i_data_mark = m;
        @(negedge i_clock);
        i_data_valid = 1'b0;
    endtask : put
    // six words, first word in the top bits
    task automatic send(input logic [11:0] w);
        for (int i = 5; i >= 0; i--) begin
            put(w[2*i+:2]);
        end
    endtask : send
    // spaces first, so a mode change never turns a data edge into a mark
    task automatic prep(input logic mode);
        i_clocked_mode = mode;
        send(12'h000);
        repeat (250) @(negedge i_clock);
        clear();
    endtask : prep
    task automatic run_clocked;
        prep(1'b1);
        check("clocked mode", 16'h0001, {15'h0000, o_clocked_mode});
        send(12'hA71);
        repeat (250) @(negedge i_clock);
        check("tip count", 16'h0002, n_tip);
        check("ring count", 16'h0002, n_ring);
        check("double flags", 16'h0001, n_dbl);
        check("repeat flags", 16'h0002, n_rep);
    endtask : run_clocked
    task automatic run_clockless;
        prep(1'b0);
        check("clockless mode", 16'h0000, {15'h0000, o_clocked_mode});
        send(12'h924);
        repeat (250) @(negedge i_clock);
        check("tip count", 16'h0002, n_tip);
        check("ring count", 16'h0002, n_ring);
        check("rz high time", 16'(e1tii_pkg::BIT_CYCLES), n_pos_hi);
        check("clock edges", 16'h0000, n_clk_edge);
        check("repeat flags", 16'h0000, n_rep);
    endtask : run_clockless
    // hold a word up until the buffer refuses and for 100 cycles more, then let it drain fully
    task automatic run_buffer;
        int k;
        clear();
        k = 0;
        @(negedge i_clock);
        i_data_valid = 1'b1;
        i_data_mark = 2'h2;
        while (o_data_ready !== 1'b0 && k < 50) begin
            @(negedge i_clock);
            k++;
        end
        check("ready full", 16'h0000, {15'h0000, o_data_ready});
        repeat (100) @(negedge i_clock);
        i_data_valid = 1'b0;
        repeat (300) @(negedge i_clock);
        check("words taken", 16'h0001, {15'h0000, n_take >= 16'(e1tii_pkg::BUF_DEPTH)});
        check("marks sent", n_take, n_tip);
    endtask : run_buffer
    task automatic close_out;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        i_rst = 1'b1;
        i_clocked_mode = 1'b0;
        i_data_valid = 1'b0;
        i_data_mark = 2'h0;
        mismatches = 0;
        samples_checked = 0;
        clear();
        repeat (3) @(negedge i_clock);
        check("line in reset", 16'h0000, {14'h0000, o_line_out_tip, o_line_out_ring});
        i_rst = 1'b0;
        run_clocked();
        run_clockless();
        run_buffer();
        close_out();
    end
    // whole run needs about 2200 cycles
    initial begin
        repeat (20000) @(posedge i_clock);
        mismatches++;
        close_out();
    end
endmodule : testbench
